// [common/emb_pkg.sv]
// Constants, types and register map of the external memory bus interface
package emb_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_P0_DATA = 8'h08;
	localparam logic [7:0] OFF_P0_DIR = 8'h0c;
	localparam logic [7:0] OFF_R0_DATA = 8'h10;
	localparam logic [7:0] OFF_R1_DATA = 8'h14;
	localparam logic [7:0] OFF_R2_DATA = 8'h18;
	localparam logic [7:0] OFF_R3_DATA = 8'h1c;
	localparam logic [7:0] OFF_R0_HIZ = 8'h20;
	localparam logic [7:0] OFF_R1_HIZ = 8'h24;
	localparam logic [7:0] OFF_R2_HIZ = 8'h28;
	localparam logic [7:0] OFF_R3_HIZ = 8'h2c;
	localparam logic [7:0] RST_PORT_DATA = 8'h00;
	localparam logic [7:0] RST_PORT_DIR = 8'h00;
	localparam logic [7:0] RST_PORT_HIZ = 8'h00;
	localparam logic [1:0] BOOT_SAMPLE_CYC = 2'h2;
	localparam logic [1:0] HALF_PER_CYCLE = 2'h2;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_X64K = 2'h1,
		MODE_X4M_MIN = 2'h2,
		MODE_X4M_MAX = 2'h3
	} emb_mode_t;

	// Chip enable window size select: 8KB, 16KB, 32KB, 64KB
	localparam logic [1:0] SZ_8K = 2'h0;
	localparam logic [1:0] SZ_16K = 2'h1;
	localparam logic [1:0] SZ_32K = 2'h2;
	localparam logic [1:0] SZ_64K = 2'h3;

	// Inserted half-cycle wait states per selection
	localparam logic [3:0] WAIT_HALF [4] = '{4'h0, 4'h4, 4'h8, 4'hc};

	typedef struct packed {
		logic [5:0] rsv_hi;
		logic [1:0] wait_sel;
		logic rsv_lo;
		logic [2:0] ce_sel;
		logic [1:0] ce_size;
		emb_mode_t mode;
	} emb_ctrl_t;
	localparam logic [15:0] CTRL_WMASK = 16'h037f;

	typedef struct packed {
		logic [7:0] data_pins;
		logic [4:0] rsv;
		logic busy;
		logic boot_done;
		logic ext_boot;
	} emb_stat_t;

	typedef struct packed {
		logic wr;
		logic [23:0] addr;
		logic [7:0] wdata;
	} emb_cpu_req_t;

	// Decoder window bounds
	localparam logic [23:0] A_000000 = 24'h000000;
	localparam logic [23:0] A_001FFF = 24'h001fff;
	localparam logic [23:0] A_002000 = 24'h002000;
	localparam logic [23:0] A_003FFF = 24'h003fff;
	localparam logic [23:0] A_004000 = 24'h004000;
	localparam logic [23:0] A_005FFF = 24'h005fff;
	localparam logic [23:0] A_007000 = 24'h007000;
	localparam logic [23:0] A_007FFF = 24'h007fff;
	localparam logic [23:0] A_008000 = 24'h008000;
	localparam logic [23:0] A_009FFF = 24'h009fff;
	localparam logic [23:0] A_00A000 = 24'h00a000;
	localparam logic [23:0] A_00AFFF = 24'h00afff;
	localparam logic [23:0] A_00B000 = 24'h00b000;
	localparam logic [23:0] A_00BFFF = 24'h00bfff;
	localparam logic [23:0] A_00C000 = 24'h00c000;
	localparam logic [23:0] A_00DFFF = 24'h00dfff;
	localparam logic [23:0] A_00EFFF = 24'h00efff;
	localparam logic [23:0] A_00F000 = 24'h00f000;
	localparam logic [23:0] A_00FFFF = 24'h00ffff;
	localparam logic [23:0] A_010000 = 24'h010000;
	localparam logic [23:0] A_3FFFFF = 24'h3fffff;
	localparam logic [23:0] A_400000 = 24'h400000;
	localparam logic [23:0] A_7FFFFF = 24'h7fffff;
	localparam logic [23:0] A_800000 = 24'h800000;
	localparam logic [23:0] A_BFFFFF = 24'hbfffff;
	localparam logic [23:0] A_C00000 = 24'hc00000;
	localparam logic [23:0] A_FFFFFF = 24'hffffff;
endpackage : emb_pkg

// [src/emb_bus.sv]
// External memory bus interface: pin sharing, chip enable decoder, wait control
// Overview of operation
// (R1) Data bus pins act as 8-bit port in single chip, data bus when expanded.
// (R2) Port data and direction registers stay readable and writable while detached.
// (R3) Optional pull-up per data line is on only while that line is input.
// (R4) 22 address pins shared with output ports; all port bits in single chip.
// (R5) Expanded 64K: low 16 pins carry address, upper 6 stay port bits.
// (R6) Both 4M modes: all 22 pins carry the address bus.
// (R7) Detached output port data and high-impedance registers remain read/write storage.
// (R8) Read and write strobe pins are port bits in single chip, strobes expanded.
// (R9) Strobes assert only for external area accesses, never for internal memory.
// (R10) Three low chip enables; software selects enable or port per pin.
// (R11) A chip enable goes low only for external accesses in its window.
// (R12) All chip enables held high during halt or sleep standby.
// (R13) 64K internal boot windows follow the selected 8KB, 16KB or 32KB size.
// (R14) 64K external boot windows follow the selected 8KB to 64KB size.
// (R15) 4M modes: enables 1 and 2 fixed quarters, enable 0 depends on boot.
// (R16) Software selects 0, 4, 8 or 12 wait states for external cycles.
// (R17) Each wait state lasts half a clock cycle.
// (R18) Waits go between third and fourth bus states, lengthening the strobe.
// (R19) No waits for internal accesses or on the low-speed oscillator clock.
// (R20) After reset mode is single chip, or the preset mode with external boot.
// (R21) External device drives read data before strobe end and latches write data.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module emb_bus
	import emb_pkg::*;
#(
	parameter emb_mode_t BOOT_PRESET_MODE = MODE_X64K,
	parameter bit PULLUP_OPT = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_req,
	input wire emb_cpu_req_t cpu_cmd,
	output logic cpu_ack,
	output logic [7:0] cpu_rdata,
	input wire logic cpu_standby,
	input wire logic low_speed_oscillator_clock,
	input wire logic external_boot_mode_n,
	input wire logic [7:0] ext_data_lines_i,
	output logic [7:0] ext_data_lines_o,
	output logic [7:0] ext_data_lines_oe,
	output logic [7:0] ext_data_pullup_en,
	output logic [21:0] ext_address_lines_o,
	output logic [21:0] ext_address_lines_oe,
	output logic read_strobe_n_o,
	output logic read_strobe_oe,
	output logic write_strobe_n_o,
	output logic write_strobe_oe,
	output logic [2:0] chip_enable_n_o,
	output logic [2:0] chip_enable_oe
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_T1 = 6'b000010,
		ST_T2 = 6'b000100,
		ST_T3 = 6'b001000,
		ST_TW = 6'b010000,
		ST_T4 = 6'b100000
	} emb_state_t;

	emb_state_t st;
	emb_state_t next_st;
	emb_ctrl_t ctrl;
	logic [7:0] p0_data, p0_dir;
	logic [7:0] r0_data, r1_data, r2_data, r3_data;
	logic [7:0] r0_hiz, r1_hiz, r2_hiz, r3_hiz;
	logic xb_s1, xb_s2;
	logic [7:0] din_s1, din_s2;
	logic [1:0] boot_cnt;
	logic boot_done, ext_boot;
	logic [21:0] addr_q;
	logic [7:0] dout_q;
	logic dout_oe_q;
	logic rd_n, wr_n, cur_wr, cur_ext, cur_slow;
	logic [2:0] ce_n, cur_ce;
	logic [2:0] wcnt, wtotal;
	logic take, take_ext;
	logic [2:0] dec_ce;
	logic exp_mode, hi_bus;
	logic [21:0] bus_mask, port_all, hiz_all;
	logic [2:0] ce_pin_sel;
	logic apb_setup, apb_wr;
	logic [3:0] slen;

	function automatic logic inr(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : inr

	function automatic logic ext_area(input logic [23:0] a, input emb_mode_t m,
		input logic xb);
		logic r;
		r = 1'b0;
		case (m)
			MODE_X64K: r = xb ? inr(a, A_000000, A_00EFFF) : inr(a, A_007000, A_00EFFF);
			MODE_X4M_MIN, MODE_X4M_MAX: begin
				if (xb)
					r = inr(a, A_000000, A_BFFFFF) && !inr(a, A_00F000, A_00FFFF);
				else
					r = (a >= A_400000);
			end
			default: r = 1'b0;
		endcase
		return r;
	endfunction : ext_area

	function automatic logic [2:0] ce_decode(input logic [23:0] a, input emb_mode_t m,
		input logic xb, input logic [1:0] sz);
		logic [2:0] c;
		c = 3'b000;
		if (m == MODE_X64K && !xb) begin // R13
			case (sz)
				SZ_8K: c = {inr(a, A_00C000, A_00DFFF), inr(a, A_00A000, A_00BFFF),
					inr(a, A_008000, A_009FFF)};
				SZ_16K: c = {1'b0, inr(a, A_00B000, A_00EFFF), inr(a, A_007000, A_00AFFF)};
				SZ_32K: c = {2'b00, inr(a, A_008000, A_00EFFF)};
				default: c = 3'b000;
			endcase
		end else if (m == MODE_X64K) begin // R14
			case (sz)
				SZ_8K: c = {inr(a, A_004000, A_005FFF), inr(a, A_002000, A_003FFF),
					inr(a, A_000000, A_001FFF)};
				SZ_16K: c = {inr(a, A_008000, A_00BFFF), inr(a, A_004000, A_007FFF),
					inr(a, A_000000, A_003FFF)};
				SZ_32K: c = {1'b0, inr(a, A_008000, A_00EFFF), inr(a, A_000000, A_007FFF)};
				default: c = {2'b00, inr(a, A_000000, A_00EFFF)};
			endcase
		end else if (m == MODE_X4M_MIN || m == MODE_X4M_MAX) begin // R15
			c[1] = inr(a, A_400000, A_7FFFFF);
			c[2] = inr(a, A_800000, A_BFFFFF);
			c[0] = xb ? (inr(a, A_000000, A_00EFFF) || inr(a, A_010000, A_3FFFFF))
				: inr(a, A_C00000, A_FFFFFF);
		end
		return c;
	endfunction : ce_decode

	// Strap and data pins come from outside: two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xb_s1 <= 1'b0;
			xb_s2 <= 1'b0;
			din_s1 <= 8'h00;
			din_s2 <= 8'h00;
		end else begin
			xb_s1 <= !external_boot_mode_n;
			xb_s2 <= xb_s1;
			din_s1 <= ext_data_lines_i;
			din_s2 <= din_s1;
		end
	end

	// Strap caught once the synchroniser has settled after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_cnt <= 2'h0;
			boot_done <= 1'b0;
			ext_boot <= 1'b0;
		end else if (!boot_done) begin
			if (boot_cnt == BOOT_SAMPLE_CYC) begin
				boot_done <= 1'b1;
				ext_boot <= xb_s2;
			end else begin
				boot_cnt <= boot_cnt + 2'h1;
			end
		end
	end

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr > OFF_R3_HIZ || paddr[1:0] != 2'b00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else if (!boot_done) begin
			if (boot_cnt == BOOT_SAMPLE_CYC)
				ctrl.mode <= xb_s2 ? BOOT_PRESET_MODE : MODE_SINGLE; // R20
		end else if (apb_wr && paddr == OFF_CTRL) begin
			ctrl <= emb_ctrl_t'(pwdata[15:0] & CTRL_WMASK);
			// Single chip needs the internal program memory
			if (ext_boot && emb_mode_t'(pwdata[1:0]) == MODE_SINGLE)
				ctrl.mode <= ctrl.mode;
		end
	end

	// Port storage is always reachable, whatever the pins are doing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_data <= RST_PORT_DATA;
			p0_dir <= RST_PORT_DIR;
			r0_data <= RST_PORT_DATA;
			r1_data <= RST_PORT_DATA;
			r2_data <= RST_PORT_DATA;
			r3_data <= RST_PORT_DATA;
			r0_hiz <= RST_PORT_HIZ;
			r1_hiz <= RST_PORT_HIZ;
			r2_hiz <= RST_PORT_HIZ;
			r3_hiz <= RST_PORT_HIZ;
		end else if (apb_wr) begin
			case (paddr) // R2 R7
				OFF_P0_DATA: p0_data <= pwdata[7:0];
				OFF_P0_DIR: p0_dir <= pwdata[7:0];
				OFF_R0_DATA: r0_data <= pwdata[7:0];
				OFF_R1_DATA: r1_data <= pwdata[7:0];
				OFF_R2_DATA: r2_data <= pwdata[7:0];
				OFF_R3_DATA: r3_data <= {5'h00, pwdata[2:0]};
				OFF_R0_HIZ: r0_hiz <= pwdata[7:0];
				OFF_R1_HIZ: r1_hiz <= pwdata[7:0];
				OFF_R2_HIZ: r2_hiz <= pwdata[7:0];
				OFF_R3_HIZ: r3_hiz <= {5'h00, pwdata[2:0]};
				default: ;
			endcase
		end
	end

	// Read data captured in the setup phase so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (apb_setup) begin
			case (paddr)
				OFF_CTRL: prdata <= {16'h0, ctrl};
				OFF_STAT: prdata <= {16'h0, emb_stat_t'({din_s2, 5'h00,
					(st != ST_IDLE), boot_done, ext_boot})};
				OFF_P0_DATA: prdata <= {24'h0, p0_data};
				OFF_P0_DIR: prdata <= {24'h0, p0_dir};
				OFF_R0_DATA: prdata <= {24'h0, r0_data};
				OFF_R1_DATA: prdata <= {24'h0, r1_data};
				OFF_R2_DATA: prdata <= {24'h0, r2_data};
				OFF_R3_DATA: prdata <= {24'h0, r3_data};
				OFF_R0_HIZ: prdata <= {24'h0, r0_hiz};
				OFF_R1_HIZ: prdata <= {24'h0, r1_hiz};
				OFF_R2_HIZ: prdata <= {24'h0, r2_hiz};
				OFF_R3_HIZ: prdata <= {24'h0, r3_hiz};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// Standby blocks new accesses; a held request waits for the ack to drop
	assign take = cpu_req && !cpu_ack && !cpu_standby && st == ST_IDLE;
	assign take_ext = take && ext_area(cpu_cmd.addr, ctrl.mode, ext_boot); // R9
	assign dec_ce = ce_decode(cpu_cmd.addr, ctrl.mode, ext_boot, ctrl.ce_size);
	// Half-cycle states paired into whole clocks; none on the slow clock
	assign wtotal = cur_slow ? 3'h0
		: 3'(WAIT_HALF[ctrl.wait_sel] / 4'(HALF_PER_CYCLE)); // R16 R17 R19

	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: next_st = take_ext ? ST_T1 : ST_IDLE;
			ST_T1: next_st = ST_T2;
			ST_T2: next_st = ST_T3;
			ST_T3: next_st = (wtotal == 3'h0) ? ST_T4 : ST_TW; // R18
			ST_TW: next_st = (wcnt == 3'h0) ? ST_T4 : ST_TW;
			ST_T4: next_st = ST_IDLE;
			default: next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= ST_IDLE;
		else
			st <= next_st;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wcnt <= 3'h0;
		else if (st == ST_T3)
			wcnt <= wtotal - 3'h1;
		else if (st == ST_TW)
			wcnt <= wcnt - 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_wr <= 1'b0;
			cur_ext <= 1'b0;
			cur_slow <= 1'b0;
			cur_ce <= 3'b000;
			addr_q <= 22'h0;
			dout_q <= 8'h00;
		end else if (take) begin
			cur_wr <= cpu_cmd.wr;
			cur_ext <= take_ext;
			cur_slow <= low_speed_oscillator_clock;
			cur_ce <= take_ext ? dec_ce : 3'b000;
			if (take_ext) begin
				addr_q <= cpu_cmd.addr[21:0];
				dout_q <= cpu_cmd.wdata;
			end
		end
	end

	// Internal accesses answer at once; external ones at the end of T4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_ack <= 1'b0;
			cpu_rdata <= 8'h00;
		end else begin
			cpu_ack <= (take && !take_ext) || st == ST_T4;
			if (st == ST_T4 && !cur_wr)
				cpu_rdata <= din_s2; // R21
		end
	end

	// Strobes low over T2, T3 and the waits; high again in T4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else if (st == ST_T1) begin
			rd_n <= cur_wr;
			wr_n <= !cur_wr;
		end else if (next_st == ST_T4 || st == ST_IDLE) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ce_n <= 3'b111;
		else if (cpu_standby)
			ce_n <= 3'b111; // R12
		else if (take_ext)
			ce_n <= ~dec_ce; // R11
		else if (st == ST_T4)
			ce_n <= 3'b111;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dout_oe_q <= 1'b0;
		else if (take_ext && cpu_cmd.wr)
			dout_oe_q <= 1'b1;
		else if (st == ST_T4)
			dout_oe_q <= 1'b0;
	end

	// Pin sharing muxes
	assign exp_mode = (ctrl.mode != MODE_SINGLE);
	assign hi_bus = (ctrl.mode == MODE_X4M_MIN || ctrl.mode == MODE_X4M_MAX); // R6
	assign bus_mask = {{6{hi_bus}}, {16{exp_mode}}}; // R4 R5
	assign port_all = {r2_data[5:0], r1_data, r0_data};
	assign hiz_all = {r2_hiz[5:0], r1_hiz, r0_hiz};
	assign ext_address_lines_o = (addr_q & bus_mask) | (port_all & ~bus_mask);
	assign ext_address_lines_oe = bus_mask | ~hiz_all;
	assign read_strobe_n_o = exp_mode ? rd_n : r2_data[6]; // R8
	assign read_strobe_oe = exp_mode || !r2_hiz[6];
	assign write_strobe_n_o = exp_mode ? wr_n : r2_data[7];
	assign write_strobe_oe = exp_mode || !r2_hiz[7];
	assign ce_pin_sel = {3{exp_mode}} & ctrl.ce_sel; // R10
	assign chip_enable_n_o = (ce_n & ce_pin_sel) | (r3_data[2:0] & ~ce_pin_sel);
	assign chip_enable_oe = ce_pin_sel | ~r3_hiz[2:0];
	assign ext_data_lines_o = exp_mode ? dout_q : p0_data; // R1
	assign ext_data_lines_oe = exp_mode ? {8{dout_oe_q}} : p0_dir;
	assign ext_data_pullup_en = {8{PULLUP_OPT}} & ~ext_data_lines_oe; // R3

	// Strobe length helper for checking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			slen <= 4'h0;
		else if (!rd_n || !wr_n)
			slen <= slen + 4'h1;
		else
			slen <= 4'h0;
	end

	AST_STANDBY_CE: assert property (@(posedge pclk) disable iff (!presetn) // R12
		cpu_standby |=> ce_n == 3'b111) else $error("chip enable low in standby");
	AST_SINGLE_PORT: assert property (@(posedge pclk) disable iff (!presetn) // R4
		ctrl.mode == MODE_SINGLE |-> ext_address_lines_o == port_all
		&& read_strobe_n_o == r2_data[6]) else $error("single chip pins not port");
	AST_64K_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // R5
		ctrl.mode == MODE_X64K |-> ext_address_lines_o[21:16] == r2_data[5:0]
		&& ext_address_lines_o[15:0] == addr_q[15:0]) else $error("64K pin split wrong");
	AST_4M_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // R6
		hi_bus |-> ext_address_lines_o == addr_q) else $error("4M address not on pins");
	AST_STROBE_EXT: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(!rd_n || !wr_n) |-> cur_ext) else $error("strobe on internal access");
	AST_CE_MATCH: assert property (@(posedge pclk) disable iff (!presetn) // R11
		ce_n != 3'b111 |-> cur_ext && ~ce_n == cur_ce) else $error("chip enable mismatch");
	AST_WAIT_LEN: assert property (@(posedge pclk) disable iff (!presetn) // R18
		st == ST_T4 |-> slen == 4'(wtotal) + 4'h2) else $error("strobe length wrong");
	AST_NO_WAIT_SLOW: assert property (@(posedge pclk) disable iff (!presetn) // R19
		st == ST_T3 && cur_slow |=> st == ST_T4) else $error("wait on slow clock");
	AST_INT_FAST: assert property (@(posedge pclk) disable iff (!presetn) // R9
		take && !take_ext |=> cpu_ack && st == ST_IDLE && rd_n && wr_n)
		else $error("internal access not immediate");
	AST_RESET_MODE: assert property (@(posedge pclk) disable iff (!presetn) // R20
		$rose(boot_done) |-> ctrl.mode == (ext_boot ? BOOT_PRESET_MODE : MODE_SINGLE))
		else $error("mode after reset wrong");
	AST_PULLUP: assert property (@(posedge pclk) disable iff (!presetn) // R3
		exp_mode && dout_oe_q |-> ext_data_pullup_en == 8'h00) else $error("pull-up on output");
endmodule : emb_bus

// [test/emb_mem_model.sv]
// Behavioural external memory chip on the expansion bus
`timescale 1ns/1ps
module emb_mem_model
	import emb_pkg::*;
(
	input wire logic pclk,
	input wire logic slow,
	input wire logic [21:0] addr,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [2:0] ce_n,
	input wire logic [7:0] din,
	output logic [7:0] dout,
	output logic doe
);
	logic [7:0] mem [256];
	logic sel;
	logic rd_d = 1'b0;
	logic [1:0] age = 2'h0;
	assign sel = ~&ce_n;
	// Latch every strobe cycle, so the last value before strobe end wins
	always_ff @(posedge pclk) begin
		if (~wr_n & sel) begin
			mem[addr[7:0]] <= din;
		end
	end
	always @(posedge pclk) begin
		rd_d <= ~rd_n & sel;
		age <= (~rd_n & sel) ? age + {1'b0, age != 2'h3} : 2'h0;
	end
	// Hold one cycle past strobe end; a slow part shows junk early on
	assign doe = (~rd_n & sel) | rd_d;
	assign dout = (slow && age < 2'h2) ? ~mem[addr[7:0]] : mem[addr[7:0]];
endmodule : emb_mem_model

// [test/tb_top.sv]
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module tb_top;
	import emb_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic [7:0] paddr, cpu_rdata, d_o, d_oe, d_pu, m_d, bus;
	logic [7:0] last_bus = 8'h00;
	logic [31:0] pwdata, prdata, rd;
	logic cpu_req, cpu_ack, cpu_standby, slow_clk, boot_n, slow_dev, m_oe;
	emb_cpu_req_t cpu_cmd;
	logic [21:0] a_o, a_oe, a_seen;
	logic rd_n, rd_oe, wr_n, wr_oe;
	logic [2:0] ce_n, ce_oe, ce_seen;
	int failures, n_checks, cyc, rd_cnt, wr_cnt, c0;

	emb_bus uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd), .cpu_ack(cpu_ack),
		.cpu_rdata(cpu_rdata), .cpu_standby(cpu_standby),
		.low_speed_oscillator_clock(slow_clk), .external_boot_mode_n(boot_n),
		.ext_data_lines_i(bus), .ext_data_lines_o(d_o), .ext_data_lines_oe(d_oe),
		.ext_data_pullup_en(d_pu), .ext_address_lines_o(a_o), .ext_address_lines_oe(a_oe),
		.read_strobe_n_o(rd_n), .read_strobe_oe(rd_oe), .write_strobe_n_o(wr_n),
		.write_strobe_oe(wr_oe), .chip_enable_n_o(ce_n), .chip_enable_oe(ce_oe));
	emb_mem_model mem (.pclk(pclk), .slow(slow_dev), .addr(a_o), .rd_n(rd_n), .wr_n(wr_n),
		.ce_n(ce_n), .din(bus), .dout(m_d), .doe(m_oe));

	// Released lines float to the pull-up, else away from the last level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (d_oe[i]) bus[i] = d_o[i];
			else if (m_oe) bus[i] = m_d[i];
			else bus[i] = d_pu[i] | ~last_bus[i];
		end
	end
	always @(posedge pclk) last_bus <= bus;

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] sz,
		input logic [2:0] sel, input logic [1:0] ws);
		return {22'h0, ws, 1'b0, sel, sz, m};
	endfunction : ctrl

	// Idle cycle after each transfer keeps psel from two writes in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			results();
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic cpu(input logic w, input logic [23:0] a, input logic [7:0] d);
		cyc = 0;
		rd_cnt = 0;
		wr_cnt = 0;
		ce_seen = 3'h7;
		cpu_req <= 1'b1;
		cpu_cmd <= {w, a, d};
		do begin
			@(posedge pclk);
			#1;
			cyc++;
			rd_cnt += int'(rd_n === 1'b0);
			wr_cnt += int'(wr_n === 1'b0);
			ce_seen &= ce_n;
			if (ce_n !== 3'h7) a_seen = a_o;
		end while (cpu_ack !== 1'b1 && cyc < 200);
		if (cyc >= 200) begin
			failures++;
			results();
		end
		@(posedge pclk);
		cpu_req <= 1'b0;
		#1;
		chk("ack pulse", 0, cpu_ack);
		@(posedge pclk);
	endtask : cpu

	task automatic dec(input logic [1:0] m, input logic [1:0] sz, input logic [23:0] a,
		input logic [2:0] e);
		apb(1'b1, OFF_CTRL, ctrl(m, sz, 3'h7, 2'h0));
		cpu(1'b0, a, 8'h00);
		chk("ce decode", e, ce_seen);
		chk("read strobe", (e == 3'h7) ? 0 : 2, rd_cnt);
		if (e != 3'h7) chk("addr pins", (m > 1) ? a[21:0] : {6'h05, a[15:0]}, a_seen);
	endtask : dec

	task automatic rst(input logic b);
		boot_n <= b;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : rst

	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		results();
	end

	initial begin
		failures = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_req = 1'b0;
		cpu_cmd = '0;
		cpu_standby = 1'b0;
		slow_clk = 1'b0;
		slow_dev = 1'b0;
		boot_n = 1'b1;
		@(posedge pclk);
		rst(1'b1);
		chk("addr oe", 22'h3fffff, a_oe);
		chk("pull-ups", 8'hff, d_pu);
		apb(1'b0, OFF_STAT, 0);
		chk("boot stat", 2'h2, rd[1:0]);
		apb(1'b0, OFF_CTRL, 0);
		chk("mode", MODE_SINGLE, rd[1:0]);
		apb(1'b1, OFF_P0_DATA, 8'ha5);
		apb(1'b1, OFF_P0_DIR, 8'hf0);
		apb(1'b1, OFF_R0_DATA, 8'h12);
		apb(1'b1, OFF_R1_DATA, 8'h34);
		apb(1'b1, OFF_R2_DATA, 8'hc5);
		apb(1'b1, OFF_R3_DATA, 8'h05);
		apb(1'b1, OFF_R0_HIZ, 8'h0f);
		apb(1'b1, OFF_R2_HIZ, 8'hc0);
		apb(1'b1, OFF_R3_HIZ, 8'h07);
		chk("port data", 8'ha5, d_o);
		chk("port dir", 8'hf0, d_oe);
		chk("pull-up in", 8'h0f, d_pu);
		chk("addr port", 22'h053412, a_o);
		chk("hiz", 22'h3ffff0, a_oe);
		chk("strobe port", 2'h3, {wr_n, rd_n});
		chk("ce port", 3'h5, ce_n);
		chk("strobe oe port", 2'h0, {wr_oe, rd_oe});
		chk("ce oe port", 3'h0, ce_oe);
		apb(1'b1, OFF_R0_HIZ, 8'h00);
		apb(1'b0, 8'h30, 0);
		chk("unmapped err", 1, slv);
		chk("unmapped data", 0, rd);
		apb(1'b1, OFF_CTRL, ctrl(MODE_SINGLE, SZ_8K, 3'h7, 2'h3));
		cpu(1'b0, 24'h008000, 8'h00);
		chk("single chip", 32'h50001, {ce_seen, rd_cnt[7:0], cyc[7:0]});
		apb(1'b1, OFF_CTRL, ctrl(MODE_X64K, SZ_8K, 3'h7, 2'h0));
		chk("data oe idle", 8'h00, d_oe);
		apb(1'b0, OFF_P0_DATA, 0);
		chk("p0 kept", 8'ha5, rd);
		apb(1'b0, OFF_R0_DATA, 0);
		chk("r0 kept", 8'h12, rd);
		chk("upper port", 6'h05, a_o[21:16]);
		chk("strobe oe bus", 2'h3, {wr_oe, rd_oe});
		cpu(1'b1, 24'h008055, 8'h3c);
		chk("write strobe", 32'h20006, {wr_cnt[7:0], rd_cnt[7:0], 5'h0, ce_seen});
		cpu(1'b0, 24'h008055, 8'h00);
		chk("read data", 8'h3c, cpu_rdata);
		c0 = cyc;
		for (int ws = 1; ws < 4; ws++) begin
			apb(1'b1, OFF_CTRL, ctrl(MODE_X64K, SZ_8K, 3'h7, ws[1:0]));
			cpu(1'b0, 24'h008055, 8'h00);
			chk("wait data", 8'h3c, cpu_rdata);
			chk("strobe len", 2 + 2 * ws, rd_cnt);
			chk("ack delay", c0 + 2 * ws, cyc);
		end
		slow_dev <= 1'b1;
		apb(1'b1, OFF_CTRL, ctrl(MODE_X64K, SZ_8K, 3'h7, 2'h2));
		cpu(1'b0, 24'h008055, 8'h00);
		chk("slow part", 8'h3c, cpu_rdata);
		slow_dev <= 1'b0;
		slow_clk <= 1'b1;
		apb(1'b1, OFF_CTRL, ctrl(MODE_X64K, SZ_8K, 3'h7, 2'h3));
		cpu(1'b0, 24'h008055, 8'h00);
		chk("slow clock", 2, rd_cnt);
		slow_clk <= 1'b0;
		cpu(1'b0, 24'h00f010, 8'h00);
		chk("internal", 1, cyc + rd_cnt);
		cpu_standby <= 1'b1;
		fork
			cpu(1'b0, 24'h008055, 8'h00);
			begin
				repeat (8) @(posedge pclk);
				#1;
				chk("standby", 4'he, {ce_n, cpu_ack});
				@(posedge pclk);
				cpu_standby <= 1'b0;
			end
		join
		chk("standby held", 1, cyc > 9);
		apb(1'b1, OFF_CTRL, ctrl(MODE_X64K, SZ_8K, 3'h6, 2'h0));
		cpu(1'b1, 24'h008056, 8'h77);
		chk("ce as port", 3'h7, ce_seen);
		chk("ce oe sel", 3'h6, ce_oe);
		dec(MODE_X64K, SZ_8K, 24'h009fff, 3'h6);
		dec(MODE_X64K, SZ_8K, 24'h00a000, 3'h5);
		dec(MODE_X64K, SZ_8K, 24'h00dfff, 3'h3);
		dec(MODE_X64K, SZ_16K, 24'h007000, 3'h6);
		dec(MODE_X64K, SZ_16K, 24'h00b000, 3'h5);
		dec(MODE_X64K, SZ_32K, 24'h00efff, 3'h6);
		dec(MODE_X64K, SZ_32K, 24'h006fff, 3'h7);
		for (int m = 2; m < 4; m++) begin
			dec(m[1:0], SZ_8K, 24'h400000, 3'h5);
			dec(m[1:0], SZ_8K, 24'hbfffff, 3'h3);
			dec(m[1:0], SZ_8K, 24'hc00000, 3'h6);
			dec(m[1:0], SZ_8K, 24'h000100, 3'h7);
		end
		rst(1'b0);
		apb(1'b1, OFF_CTRL, ctrl(MODE_SINGLE, SZ_8K, 3'h7, 2'h0));
		apb(1'b0, OFF_STAT, 0);
		chk("ext boot", 2'h3, rd[1:0]);
		apb(1'b0, OFF_CTRL, 0);
		chk("preset mode", MODE_X64K, rd[1:0]);
		apb(1'b1, OFF_R2_DATA, 8'hc5);
		dec(MODE_X64K, SZ_8K, 24'h002000, 3'h5);
		dec(MODE_X64K, SZ_8K, 24'h005fff, 3'h3);
		dec(MODE_X64K, SZ_16K, 24'h00bfff, 3'h3);
		dec(MODE_X64K, SZ_32K, 24'h008000, 3'h5);
		dec(MODE_X64K, SZ_64K, 24'h00efff, 3'h6);
		dec(MODE_X4M_MIN, SZ_8K, 24'h3fffff, 3'h6);
		dec(MODE_X4M_MAX, SZ_8K, 24'h000100, 3'h6);
		dec(MODE_X4M_MIN, SZ_8K, 24'h00f000, 3'h7);
		results();
	end
endmodule : tb_top
